// ---- haptic_frame_decoder_tb.sv ----
// bench for the frame decoder: frames, faults, frequency, level formats
// assumes step parameters shrunk to 5..40 cycles, 100 MHz clock
`timescale 1ns/100ps
module haptic_frame_decoder_tb;
  import hfd_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb, snippet_index;
  logic [1:0] bresp, rresp, attenuation, silent_steps, resp;
  logic frame_valid, resume_first_point, start_from_zero;
  logic sequence_end, memory_format_fault_event;
  logic [23:0] step_cycles;
  logic [4:0] pass_count;
  logic [8:0] drive_frequency_code;
  logic [15:0] active_period_readback;
  logic [7:0] override_drive, envelope_drive, b1, b2;
  int bad_count = 0;
  int tests_run = 0;
  int n_frame = 0, n_fault = 0, n_end = 0, nf, ne, hz;
  int unsigned stp [5] = '{5, 10, 20, 30, 40};
  logic [8:0] fc [3] = '{9'h12c, 9'h005, 9'h1ff};
  bit bo [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [7:0] ov [5] = '{8'h7f, 8'h80, 8'h00, 8'hc0, 8'h7f};
  logic [3:0] en [5] = '{4'h7, 4'h8, 4'h0, 4'hf, 4'h1};
  logic [7:0] eo [5] = '{8'h7f, 8'h81, 8'h00, 8'h00, 8'h7f};
  logic [7:0] ee [5] = '{8'h38, 8'hc8, 8'h00, 8'h78, 8'h08};
  always #5 clock = ~clock;
  // pulses are counted so no check hinges on the exact pulse cycle
  always @(posedge clock) begin
    if (frame_valid === 1'b1) n_frame++;
    if (memory_format_fault_event === 1'b1) n_fault++;
    if (sequence_end === 1'b1) n_end++;
  end
  hfd_host_model host (.clock, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  hfd_frame_decoder #(.STEP0_CYC(5), .STEP1_CYC(10), .STEP2_CYC(20),
    .STEP3_CYC(30), .STEP4_CYC(40)) dut (.clock, .resetn, .ce, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .frame_valid, .snippet_index, .attenuation, .step_cycles, .pass_count,
    .resume_first_point, .start_from_zero, .silent_steps, .sequence_end,
    .memory_format_fault_event, .drive_frequency_code,
    .active_period_readback, .override_drive, .envelope_drive);
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic feed(input logic [31:0] d);
    host.wr(A_FEED, d, resp);
  endtask : feed
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk("pass_rst", pass_count, 1);
    host.rd(A_PERIOD, rd_v, resp);
    chk("period_rst", rd_v, 32'h00009c40);
    host.rd(8'h3c, rd_v, resp);
    chk("unmapped_rd", resp, RESP_SLVERR);
    host.wr(8'h3c, 32'h0000_0001, resp);
    chk("unmapped_wr", resp, RESP_SLVERR);
    $display("test reset done");
    for (int f = 0; f < 2; f++) begin
      host.wr(A_CTRL, 32'(f), resp);
      for (int s = 0; s < 4; s++) begin
        b1 = {1'b0, s[1:0], s[1:0], 3'(2 * s)};
        b2 = {1'b1, 4'(5 * s), 2'b00, s[0]};
        nf = n_frame;
        feed(32'h300 | b1);
        feed(32'h100 | b2);
        repeat (4) @(posedge clock);
        chk("frame_cnt", n_frame - nf, 1);
        chk("index", snippet_index, {s[0], 3'(2 * s)});
        chk("atten", attenuation, s);
        chk("step", step_cycles, stp[f ? s : s + 1]);
        chk("passes", pass_count, 5 * s + 1);
        chk("resume", resume_first_point, s != 0);
        chk("silent", silent_steps, (s == 0) ? 2 : 0);
        chk("seq_start", start_from_zero, 1);
      end
    end
    // lone first byte, flushed by the end bit, after a high-index frame
    nf = n_frame;
    ne = n_end;
    feed(32'h100 | 8'h0b);
    feed(32'h400);
    repeat (5) @(posedge clock);
    chk("lone_cnt", n_frame - nf, 1);
    chk("lone_index", snippet_index, 3);
    chk("lone_passes", pass_count, 1);
    chk("lone_step", step_cycles, stp[1]);
    chk("chained", start_from_zero, 0);
    chk("seq_end", n_end - ne, 1);
    $display("test frames done");
    nf = n_frame;
    ne = n_fault;
    feed(32'h1b00 | 8'h85);
    repeat (4) @(posedge clock);
    chk("fault_cnt", n_fault - ne, 1);
    chk("fault_drop", n_frame - nf, 0);
    host.rd(A_STATUS, rd_v, resp);
    chk("fault_sticky", rd_v[0], 1);
    chk("seq_id", rd_v[7:4], 3);
    host.wr(A_STATUS, 32'h0000_0001, resp);
    host.rd(A_STATUS, rd_v, resp);
    chk("fault_clear", rd_v[0], 0);
    feed(32'h400);
    $display("test fault done");
    // tracking off before any frequency frame
    host.wr(A_CTRL, 32'h0000_0000, resp);
    for (int i = 0; i < 3; i++) begin
      feed(32'h301);
      feed(32'h100 | {1'b1, 4'h0, 1'b1, fc[i][8], 1'b0});
      feed(32'h100 | fc[i][7:0]);
      repeat (25) @(posedge clock);
      hz = 2 * fc[i];
      if (hz < 25) hz = 25;
      chk("drive_frequency_code_code", drive_frequency_code, fc[i]);
      chk("period", active_period_readback, 1000000 / hz);
    end
    feed(32'h301);
    feed(32'h180);
    repeat (25) @(posedge clock);
    chk("drive_frequency_code_held", drive_frequency_code, 9'h1ff);
    feed(32'h400);
    $display("test frequency done");
    for (int i = 0; i < 5; i++) begin
      host.wr(A_CTRL, {30'h0, bo[i], 1'b0}, resp);
      host.wr(A_LEVEL, {20'h0, en[i], ov[i]}, resp);
      repeat (3) @(posedge clock);
      chk("override", override_drive, eo[i]);
      chk("envelope", envelope_drive, ee[i]);
      host.rd(A_DRIVE, rd_v, resp);
      chk("drive_reg", rd_v[15:0], {ee[i], eo[i]});
    end
    $display("test levels done");
    wrap_up();
  end
endmodule : haptic_frame_decoder_tb

// ---- hfd_frame_decoder.sv ----
// haptic frame decoder: frame byte parsing, frequency and level formats
// assumes an AXI4-Lite master on the same clock feeding frame bytes
//
// Contract
// - first frame byte kind flag 0, else fault
// - kind flag 1 marks the optional second byte
// - first byte: flag, attenuation, step select, index low
// - second byte: flag, repeats, drive_frequency_code flag, freq8, index high
// - attenuation codes 0, -6, -12, -18 dB
// - normal step lengths 5.44 to 87.04 ms
// - fast step lengths 1.36 to 43.52 ms
// - index high bit above low bits, default 0
// - passes equal repeat count plus one
// - later passes restart from first stored point
// - frequency flag adds third byte, low eight bits
// - frequency code times 2 Hz, floor 25 Hz
// - frequency converted to period readback
// - commanded frequency held until next frequency frame
// - playback targets are sequences only
// - sequence end forces zero and stops playback
// - sequence starts at zero, frames chain amplitude
// - override two's complement, -128 read as -127
// - boost mode clamps negative override to zero
// - four-bit envelope read per boost mode
// - envelope unsigned 0..15 or signed, -8 as -7
// - index 0 is built-in silence, two steps
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module hfd_frame_decoder #(
  parameter int unsigned STEP0_CYC = hfd_pkg::STEP0_CYC,
  parameter int unsigned STEP1_CYC = hfd_pkg::STEP1_CYC,
  parameter int unsigned STEP2_CYC = hfd_pkg::STEP2_CYC,
  parameter int unsigned STEP3_CYC = hfd_pkg::STEP3_CYC,
  parameter int unsigned STEP4_CYC = hfd_pkg::STEP4_CYC
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [hfd_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [hfd_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // decoded frame
  output logic frame_valid,
  output logic [3:0] snippet_index,
  output logic [1:0] attenuation,
  output logic [23:0] step_cycles,
  output logic [4:0] pass_count,
  output logic resume_first_point,
  output logic start_from_zero,
  output logic [1:0] silent_steps,
  // sequence and fault events
  output logic sequence_end,
  output logic memory_format_fault_event,
  // drive path
  output logic [8:0] drive_frequency_code,
  output logic [15:0] active_period_readback,
  output logic [7:0] override_drive,
  output logic [7:0] envelope_drive
);
  import hfd_pkg::*;

  function automatic logic [23:0] step_lookup(input logic [2:0] idx);
    unique case (idx)
      3'h0: step_lookup = 24'(STEP0_CYC);
      3'h1: step_lookup = 24'(STEP1_CYC);
      3'h2: step_lookup = 24'(STEP2_CYC);
      3'h3: step_lookup = 24'(STEP3_CYC);
      default: step_lookup = 24'(STEP4_CYC);
    endcase
  endfunction : step_lookup

  // -128 folds to -127 so the range stays symmetric
  function automatic logic [7:0] dro_level(input logic [7:0] d,
                                           input logic boost);
    if (boost) begin
      dro_level = d[7] ? 8'h00 : d;
    end else begin
      dro_level = (d == 8'h80) ? 8'h81 : d;
    end
  endfunction : dro_level

  // scaled by 8 into the drive range, then one shift per 6 dB
  function automatic logic [7:0] env_level(input logic [3:0] e,
                                           input logic boost,
                                           input logic [1:0] att);
    logic [3:0] v;
    logic signed [7:0] s;
    v = (!boost && e == 4'h8) ? 4'h9 : e;
    s = boost ? $signed({1'b0, v, 3'h0}) : $signed({v[3], v, 3'h0});
    env_level = 8'(s >>> att);
  endfunction : env_level

  // bus registers
  logic aw_full, w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [2:0] ctrl;
  logic [7:0] dro_reg;
  logic [3:0] env_reg;
  logic fault_sticky;
  logic feed_stb, feed_byte, feed_start, feed_end;
  logic [7:0] feed_data;
  logic [3:0] seq_id;
  logic wr_do;
  logic [31:0] wd;
  logic [31:0] rd_mux;
  logic rd_ok;

  // decoder state
  hfd_state_t state, next_state, st;
  logic end_q, seq_active, first_of_seq;
  logic [1:0] p_gain, p_sel;
  logic [2:0] p_lo;
  logic [3:0] p_loop;
  logic p_f8, p_hi;
  logic bytev, emit, load_first, load_b2, fault_now;
  logic em_hi, em_fp, em_f8;
  logic [3:0] em_loop;
  logic [7:0] em_flo;

  // period divider
  logic [9:0] div_hz, rem;
  logic [19:0] quo;
  logic [4:0] div_cnt;
  logic [10:0] rsh;
  logic [9:0] next_hz;

  assign wr_do = aw_full && w_full && !bvalid;
  assign wd = wdata & {{8{wstrb[3]}}, {8{wstrb[2]}},
                       {8{wstrb[1]}}, {8{wstrb[0]}}};

  // write channel; address and data taken in either order
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      bvalid <= 1'b0;
      bresp <= RESP_OK;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        w_data <= wd;
        wready <= 1'b0;
      end
      if (wr_do) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr == A_CTRL || aw_addr == A_FEED ||
                  aw_addr == A_STATUS || aw_addr == A_LEVEL)
                 ? RESP_OK : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // software registers and the frame byte feed
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_RST;
      dro_reg <= LEVEL_RST;
      env_reg <= 4'h0;
      feed_stb <= 1'b0;
      feed_byte <= 1'b0;
      feed_start <= 1'b0;
      feed_end <= 1'b0;
      feed_data <= 8'h00;
      seq_id <= 4'h0;
    end else if (ce) begin
      feed_stb <= 1'b0;
      if (wr_do && aw_addr == A_CTRL) begin
        ctrl <= w_data[2:0];
      end
      if (wr_do && aw_addr == A_LEVEL) begin
        dro_reg <= w_data[7:0];
        env_reg <= w_data[11:8];
      end
      if (wr_do && aw_addr == A_FEED) begin
        feed_stb <= 1'b1;
        feed_data <= w_data[7:0];
        feed_byte <= w_data[FEED_BYTE_V];
        feed_start <= w_data[FEED_START];
        feed_end <= w_data[FEED_END];
        // only a sequence number can start playback
        if (w_data[FEED_START]) begin
          seq_id <= w_data[FEED_SEQ+3:FEED_SEQ];
        end
      end
    end
  end

  // fault flag: a new fault beats a same-cycle clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fault_sticky <= 1'b0;
    end else if (ce) begin
      if (fault_now) begin
        fault_sticky <= 1'b1;
      end else if (wr_do && aw_addr == A_STATUS && w_data[0]) begin
        fault_sticky <= 1'b0;
      end
    end
  end

  // frame byte parser
  always_comb begin
    st = (feed_stb && feed_start) ? S_FIRST : state;
    bytev = feed_stb && feed_byte;
    next_state = st;
    emit = 1'b0;
    load_first = 1'b0;
    load_b2 = 1'b0;
    fault_now = 1'b0;
    em_hi = 1'b0;
    em_fp = 1'b0;
    em_f8 = 1'b0;
    em_loop = 4'h0;
    em_flo = 8'h00;
    unique case (st)
      S_FIRST: begin
        if (bytev) begin
          if (feed_data[KIND_BIT]) begin
            fault_now = 1'b1;
          end else begin
            load_first = 1'b1;
            next_state = S_SECOND;
          end
        end
      end
      S_SECOND: begin
        if (bytev && feed_data[KIND_BIT]) begin
          load_b2 = 1'b1;
          if (feed_data[DRIVE_FREQUENCY_CODE_FLAG_BIT]) begin
            next_state = S_THIRD;
          end else begin
            emit = 1'b1;
            em_loop = feed_data[6:3];
            em_f8 = feed_data[1];
            em_hi = feed_data[0];
            next_state = S_FIRST;
          end
        end else if (bytev) begin
          emit = 1'b1;
          load_first = 1'b1;
        end else if (end_q) begin
          emit = 1'b1;
          next_state = S_FIRST;
        end
      end
      S_THIRD: begin
        if (bytev) begin
          emit = 1'b1;
          em_loop = p_loop;
          em_fp = 1'b1;
          em_f8 = p_f8;
          em_hi = p_hi;
          em_flo = feed_data;
          next_state = S_FIRST;
        end else if (end_q) begin
          next_state = S_FIRST;
        end
      end
      default: next_state = S_FIRST;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= S_FIRST;
      end_q <= 1'b0;
      p_gain <= 2'h0;
      p_sel <= 2'h0;
      p_lo <= 3'h0;
      p_loop <= 4'h0;
      p_f8 <= 1'b0;
      p_hi <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      end_q <= feed_stb && feed_end;
      if (load_first) begin
        p_gain <= feed_data[6:5];
        p_sel <= feed_data[4:3];
        p_lo <= feed_data[2:0];
      end
      if (load_b2) begin
        p_loop <= feed_data[6:3];
        p_f8 <= feed_data[1];
        p_hi <= feed_data[0];
      end
    end
  end

  // sequence bounds
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seq_active <= 1'b0;
      first_of_seq <= 1'b0;
      sequence_end <= 1'b0;
      memory_format_fault_event <= 1'b0;
    end else if (ce) begin
      memory_format_fault_event <= fault_now;
      sequence_end <= end_q;
      if (feed_stb && feed_start) begin
        seq_active <= 1'b1;
        first_of_seq <= 1'b1;
      end else if (emit) begin
        first_of_seq <= 1'b0;
      end
      if (end_q) begin
        seq_active <= 1'b0;
      end
    end
  end

  // frame outputs, loaded once per complete frame
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frame_valid <= 1'b0;
      snippet_index <= 4'h0;
      attenuation <= 2'h0;
      step_cycles <= 24'h00_0000;
      pass_count <= 5'h01;
      resume_first_point <= 1'b0;
      start_from_zero <= 1'b0;
      silent_steps <= 2'h0;
    end else if (ce) begin
      frame_valid <= emit;
      if (emit) begin
        snippet_index <= {em_hi, p_lo};
        attenuation <= p_gain;
        // fast scale shifts the table down by one entry
        step_cycles <= step_lookup(ctrl[CTRL_FAST] ? {1'b0, p_sel}
                                   : 3'({1'b0, p_sel} + 3'h1));
        pass_count <= 5'({1'b0, em_loop} + 5'h01);
        resume_first_point <= (em_loop != 4'h0);
        start_from_zero <= first_of_seq;
        silent_steps <= ({em_hi, p_lo} == 4'h0) ? SILENT_STEPS
                        : 2'h0;
      end
    end
  end

  // frequency hold and period conversion by restoring division
  assign rsh = {rem, quo[19]};
  always_comb begin
    next_hz = {em_f8, em_flo, 1'b0};
    if (next_hz < HZ_MIN) begin
      next_hz = HZ_MIN;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      drive_frequency_code <= 9'h000;
      div_hz <= HZ_MIN;
      rem <= 10'h000;
      quo <= 20'h0_0000;
      div_cnt <= 5'h00;
      active_period_readback <= PERIOD_RST;
    end else if (ce) begin
      // tracking owns the frequency, so frame commands are ignored then
      if (emit && em_fp && !ctrl[CTRL_TRACK]) begin
        drive_frequency_code <= {em_f8, em_flo};
        div_hz <= next_hz;
        rem <= 10'h000;
        quo <= PERIOD_NUM_US;
        div_cnt <= DIV_STEPS;
      end else if (div_cnt != 5'h00) begin
        if (rsh >= {1'b0, div_hz}) begin
          rem <= 10'(rsh - {1'b0, div_hz});
        end else begin
          rem <= rsh[9:0];
        end
        quo <= {quo[18:0], rsh >= {1'b0, div_hz}};
        div_cnt <= 5'(div_cnt - 5'h01);
        if (div_cnt == 5'h01) begin
          active_period_readback <= {quo[14:0],
                                     rsh >= {1'b0, div_hz}};
        end
      end
    end
  end

  // level formats follow boost mode live
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      override_drive <= 8'h00;
      envelope_drive <= 8'h00;
    end else if (ce) begin
      override_drive <= dro_level(dro_reg, ctrl[CTRL_BOOST]);
      envelope_drive <= env_level(env_reg, ctrl[CTRL_BOOST],
                                  attenuation);
    end
  end

  // read channel
  always_comb begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (araddr)
      A_CTRL: rd_mux = {29'h0, ctrl};
      A_STATUS: rd_mux = {24'h0, seq_id, 2'h0, seq_active, fault_sticky};
      A_FRAME: rd_mux = {17'h0, start_from_zero, silent_steps != 2'h0,
                         pass_count, p_sel, attenuation, snippet_index};
      A_DRIVE_FREQUENCY_CODE: rd_mux = {6'h0, div_hz, 7'h0, drive_frequency_code};
      A_PERIOD: rd_mux = {16'h0, active_period_readback};
      A_STEP: rd_mux = {8'h0, step_cycles};
      A_LEVEL: rd_mux = {20'h0, env_reg, dro_reg};
      A_DRIVE: rd_mux = {16'h0, envelope_drive, override_drive};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OK;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_ok ? RESP_OK : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule : hfd_frame_decoder

// ---- hfd_frame_decoder_assertions.sv ----
// checker for the frame decoder: pulse shapes, field ranges, drive limits
// assumes bind onto hfd_frame_decoder, one clock, async low reset
`timescale 1ns/100ps
module hfd_frame_decoder_assertions #(
  parameter int unsigned STEP0_CYC = 5,
  parameter int unsigned STEP1_CYC = 10,
  parameter int unsigned STEP2_CYC = 20,
  parameter int unsigned STEP3_CYC = 30,
  parameter int unsigned STEP4_CYC = 40
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // bus response
  input wire logic bvalid,
  // decoded frame
  input wire logic frame_valid,
  input wire logic [3:0] snippet_index,
  input wire logic [23:0] step_cycles,
  input wire logic [4:0] pass_count,
  input wire logic resume_first_point,
  input wire logic [1:0] silent_steps,
  // events and drive
  input wire logic sequence_end,
  input wire logic memory_format_fault_event,
  input wire logic [8:0] drive_frequency_code,
  input wire logic [15:0] active_period_readback,
  input wire logic [7:0] override_drive,
  input wire logic [7:0] envelope_drive
);
  import hfd_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // cycles since a write response; events must follow a feed write
  logic [3:0] since_b;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) since_b <= 4'hf;
    else if (bvalid) since_b <= 4'h0;
    else if (since_b != 4'hf) since_b <= since_b + 4'h1;
  end
  sequence s_frame_once;
    frame_valid ##1 !frame_valid;
  endsequence
  sequence s_fault_once;
    (since_b < 4'h6) ##1 !memory_format_fault_event;
  endsequence
  sequence s_end_once;
    (since_b < 4'h7) ##1 !sequence_end;
  endsequence
  a_frame_once: assert property (frame_valid |-> s_frame_once)
    else $error("frame pulse longer than one cycle");
  a_fault_after_write: assert property (
    memory_format_fault_event |-> s_fault_once)
    else $error("fault pulse without feed write or too long");
  a_end_after_write: assert property (
    sequence_end |-> s_end_once)
    else $error("sequence end pulse misplaced");
  a_pass_range: assert property (
    frame_valid |=> pass_count >= 5'h01 && pass_count <= 5'h10)
    else $error("pass count out of range");
  a_resume_loop: assert property (
    frame_valid |=> resume_first_point == (pass_count != 5'h01))
    else $error("resume flag disagrees with pass count");
  a_silent_index: assert property (
    frame_valid |=> silent_steps == ((snippet_index == 4'h0) ? 2'h2 : 2'h0))
    else $error("silent steps disagree with index");
  a_step_legal: assert property (
    frame_valid |=> step_cycles inside
    {STEP0_CYC, STEP1_CYC, STEP2_CYC, STEP3_CYC, STEP4_CYC})
    else $error("step length not in table");
  a_drive_frequency_code_held: assert property (
    $changed(drive_frequency_code) |-> since_b < 4'h6)
    else $error("frequency code moved without a frame");
  a_period_range: assert property (
    active_period_readback >= 16'h03d2
    && active_period_readback <= 16'h9c40)
    else $error("period outside clamped range");
  a_override_sym: assert property (override_drive != 8'h80)
    else $error("override shows most negative code");
  a_envelope_sym: assert property (envelope_drive != 8'hc0)
    else $error("envelope shows most negative code");
endmodule : hfd_frame_decoder_assertions

bind hfd_frame_decoder hfd_frame_decoder_assertions #(
  .STEP0_CYC(STEP0_CYC), .STEP1_CYC(STEP1_CYC), .STEP2_CYC(STEP2_CYC),
  .STEP3_CYC(STEP3_CYC), .STEP4_CYC(STEP4_CYC)
) u_chk (
  .clock(clock), .resetn(resetn), .bvalid(bvalid),
  .frame_valid(frame_valid), .snippet_index(snippet_index),
  .step_cycles(step_cycles), .pass_count(pass_count),
  .resume_first_point(resume_first_point), .silent_steps(silent_steps),
  .sequence_end(sequence_end),
  .memory_format_fault_event(memory_format_fault_event),
  .drive_frequency_code(drive_frequency_code),
  .active_period_readback(active_period_readback),
  .override_drive(override_drive), .envelope_drive(envelope_drive)
);

// ---- hfd_host_model.sv ----
// host side: axi4-lite master with blocking write and read tasks
// assumes callers enter a task just after a rising edge
`timescale 1ns/100ps
module hfd_host_model (
  // clock
  input wire logic clock,
  // write channels
  output logic [hfd_pkg::ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [hfd_pkg::ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  import hfd_pkg::*;
  // full-word lanes only; unstrobed lanes would be written as zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // raised in the same edge that drops the last of awvalid and wvalid
    bready <= 1'b1;
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : hfd_host_model

// ---- hfd_pkg.sv ----
// haptic frame decoder: register map, field positions, timing constants
// assumes a 100 MHz clock and a 32-bit AXI4-Lite register bus
package hfd_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FEED = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_FRAME = 8'h0c;
  localparam logic [7:0] A_DRIVE_FREQUENCY_CODE = 8'h10;
  localparam logic [7:0] A_PERIOD = 8'h14;
  localparam logic [7:0] A_STEP = 8'h18;
  localparam logic [7:0] A_LEVEL = 8'h1c;
  localparam logic [7:0] A_DRIVE = 8'h20;
  localparam int CTRL_FAST = 0;
  localparam int CTRL_BOOST = 1;
  localparam int CTRL_TRACK = 2;
  localparam int FEED_BYTE_V = 8;
  localparam int FEED_START = 9;
  localparam int FEED_END = 10;
  localparam int FEED_SEQ = 11;
  localparam int KIND_BIT = 7;
  localparam int DRIVE_FREQUENCY_CODE_FLAG_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // step lengths in ms, table index 0..4
  localparam real CLK_NS = 10.0;
  localparam real STEP0_MS = 1.36;
  localparam real STEP1_MS = 5.44;
  localparam real STEP2_MS = 21.76;
  localparam real STEP3_MS = 43.52;
  localparam real STEP4_MS = 87.04;
  localparam int unsigned STEP0_CYC = int'(STEP0_MS * 1.0e6 / CLK_NS);
  localparam int unsigned STEP1_CYC = int'(STEP1_MS * 1.0e6 / CLK_NS);
  localparam int unsigned STEP2_CYC = int'(STEP2_MS * 1.0e6 / CLK_NS);
  localparam int unsigned STEP3_CYC = int'(STEP3_MS * 1.0e6 / CLK_NS);
  localparam int unsigned STEP4_CYC = int'(STEP4_MS * 1.0e6 / CLK_NS);
  // frequency code is in 2 Hz steps, floor 25 Hz; period in microseconds
  localparam logic [9:0] HZ_MIN = 10'h019;
  localparam logic [19:0] PERIOD_NUM_US = 20'hf4240;
  localparam logic [15:0] PERIOD_RST = 16'h9c40;
  localparam logic [4:0] DIV_STEPS = 5'h14;
  localparam logic [1:0] SILENT_STEPS = 2'h2;
  typedef enum logic [2:0] {
    S_FIRST = 3'b001,
    S_SECOND = 3'b010,
    S_THIRD = 3'b100
  } hfd_state_t;
endpackage : hfd_pkg
